// ### hw/dtpg_defines.svh
// Purpose: register indices, field positions, reset values and fixed words
// Assumes: byte address of a register is four times its index
// Notes:   included by the pattern generator top and by the testbench
`ifndef DTPG_DEFINES_SVH
`define DTPG_DEFINES_SVH

// register indices (byte address = index * 4)
`define DTPG_IDX_WB_GAIN    8'h1F
`define DTPG_IDX_UW1_LOW    8'h33
`define DTPG_IDX_UW1_HIGH   8'h34
`define DTPG_IDX_UW2_LOW    8'h35
`define DTPG_IDX_UW2_HIGH   8'h36
`define DTPG_IDX_SEL_ONE    8'h37
`define DTPG_IDX_SEL_TWO    8'h38
`define DTPG_IDX_COMMON     8'h39

// field positions
`define DTPG_WB_GAIN_BIT    0
`define DTPG_COMMON_BIT     0
`define DTPG_SEL_I_LSB      0
`define DTPG_SEL_Q_LSB      4

// reset values
`define DTPG_RST_BYTE       8'h00
`define DTPG_RST_WORD       16'h0000

// fixed pattern words and saturation limits
`define DTPG_TOGGLE_A       16'h2AAA
`define DTPG_TOGGLE_B       16'h1555
`define DTPG_DESKEW_WORD    16'hAAAA
`define DTPG_SYNC_WORD      16'hFFFF
`define DTPG_SAT_POS        16'h7FFF
`define DTPG_SAT_NEG        16'h8000

`endif

// ### hw/dtpg_pkg.sv
// Purpose: types shared by the output pattern generator
// Assumes: 4-bit selector codes per output stream
// Notes:   codes not listed here fall back to live data
package dtpg_pkg;

    typedef enum logic [3:0] {
        PAT_LIVE   = 4'h0,
        PAT_ZEROS  = 4'h1,
        PAT_ONES   = 4'h2,
        PAT_TOGGLE = 4'h3,
        PAT_RAMP   = 4'h4,
        PAT_SINGLE = 4'h6,
        PAT_DOUBLE = 4'h7,
        PAT_DESKEW = 4'h8,
        PAT_SYNC   = 4'h9
    } dtpg_pattern_t;

    typedef logic [15:0] dtpg_word_t;

endpackage

// ### hw/dtpg_top.sv
// Purpose: output test pattern generator and wideband gain for two downconverter paths
// Assumes: APB3 slave, one clock, live samples arrive one per pclk cycle
// Notes:   one wait state on every APB access; outputs lag inputs by one cycle
// How it works
// - wideband gain bit doubles wideband filter output
// - doubling only on decimate-by-4/6 path
// - two user words from four byte registers
// - per-stream 4-bit selectors, I low nibble
// - code 0000 passes live converter data
// - 0001 all zeros, 0010 all ones
// - 0011 alternates toggle words 2AAAh and 1555h
// - 0100 ramp increments every clock cycle
// - 0110 outputs first user word continuously
// - 0111 alternates first and second user words
// - 1000 outputs deskew word AAAAh
// - 1001 outputs sync word FFFFh
// - common bit clear: all follow path one I
`timescale 1ns/100ps
`include "dtpg_defines.svh"

module dtpg_top
    import dtpg_pkg::*;
#(
    parameter int AW = 12
) (
    // clock and reset
    input  wire logic          pclk,
    input  wire logic          presetn,
    // apb slave
    input  wire logic [AW-1:0] paddr,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    // decimation mode: high on the wideband (by 4 or 6) filter path
    input  wire logic          wideband_path,
    // live converter samples
    input  wire logic [15:0]   conv_i1,
    input  wire logic [15:0]   conv_q1,
    input  wire logic [15:0]   conv_i2,
    input  wire logic [15:0]   conv_q2,
    // streams toward the serial output link
    output logic      [15:0]   out_i1,
    output logic      [15:0]   out_q1,
    output logic      [15:0]   out_i2,
    output logic      [15:0]   out_q2
);

    // register state
    logic            wideband_double_gain;
    logic            next_wideband_double_gain;
    dtpg_word_t      user_word_one;
    dtpg_word_t      next_user_word_one;
    dtpg_word_t      user_word_two;
    dtpg_word_t      next_user_word_two;
    logic [7:0]      path_one_pattern_select;
    logic [7:0]      next_path_one_pattern_select;
    logic [7:0]      path_two_pattern_select;
    logic [7:0]      next_path_two_pattern_select;
    logic            per_stream_select;
    logic            next_per_stream_select;
    logic [31:0]     next_prdata;
    logic            next_pready;
    logic            next_pslverr;

    // pattern state
    logic            phase;
    logic            next_phase;
    dtpg_word_t      ramp;
    dtpg_word_t      next_ramp;
    dtpg_word_t      out_q    [4];
    dtpg_word_t      next_out [4];
    dtpg_word_t      conv     [4];
    dtpg_word_t      live     [4];
    logic [3:0]      own_sel  [4];
    logic [3:0]      eff_sel  [4];

    // apb decode
    logic            access;
    logic            wr_fire;
    logic            hit;
    logic [AW-3:0]   idx;

    // doubles a signed sample, clamping instead of wrapping on overflow
    function automatic dtpg_word_t sat_double(input dtpg_word_t x);
        if (x[15] != x[14]) begin
            sat_double = x[15] ? `DTPG_SAT_NEG : `DTPG_SAT_POS;
        end else begin
            sat_double = {x[14:0], 1'b0};
        end
    endfunction

    assign access  = psel & penable;
    assign wr_fire = access & pready & pwrite;
    assign idx     = paddr[AW-1:2];

    // map of implemented words; misaligned or unlisted addresses answer with pslverr
    always_comb begin
        hit = 1'b0;
        if (paddr[1:0] == 2'b00) begin
            case (idx)
                (AW-2)'(`DTPG_IDX_WB_GAIN),
                (AW-2)'(`DTPG_IDX_UW1_LOW),
                (AW-2)'(`DTPG_IDX_UW1_HIGH),
                (AW-2)'(`DTPG_IDX_UW2_LOW),
                (AW-2)'(`DTPG_IDX_UW2_HIGH),
                (AW-2)'(`DTPG_IDX_SEL_ONE),
                (AW-2)'(`DTPG_IDX_SEL_TWO),
                (AW-2)'(`DTPG_IDX_COMMON): hit = 1'b1;
                default:                   hit = 1'b0;
            endcase
        end
    end

    // register writes and read data; pready comes one cycle into the access phase
    always_comb begin
        next_wideband_double_gain    = wideband_double_gain;
        next_user_word_one           = user_word_one;
        next_user_word_two           = user_word_two;
        next_path_one_pattern_select = path_one_pattern_select;
        next_path_two_pattern_select = path_two_pattern_select;
        next_per_stream_select       = per_stream_select;
        next_pready                  = access & ~pready;
        next_pslverr                 = access & ~pready & ~hit;
        next_prdata                  = prdata;
        if (wr_fire && hit) begin
            case (idx)
                (AW-2)'(`DTPG_IDX_WB_GAIN):
                    next_wideband_double_gain = pwdata[`DTPG_WB_GAIN_BIT];
                (AW-2)'(`DTPG_IDX_UW1_LOW):  next_user_word_one[7:0]  = pwdata[7:0];
                (AW-2)'(`DTPG_IDX_UW1_HIGH): next_user_word_one[15:8] = pwdata[7:0];
                (AW-2)'(`DTPG_IDX_UW2_LOW):  next_user_word_two[7:0]  = pwdata[7:0];
                (AW-2)'(`DTPG_IDX_UW2_HIGH): next_user_word_two[15:8] = pwdata[7:0];
                (AW-2)'(`DTPG_IDX_SEL_ONE):  next_path_one_pattern_select = pwdata[7:0];
                (AW-2)'(`DTPG_IDX_SEL_TWO):  next_path_two_pattern_select = pwdata[7:0];
                (AW-2)'(`DTPG_IDX_COMMON):
                    next_per_stream_select = pwdata[`DTPG_COMMON_BIT];
                default: next_per_stream_select = per_stream_select;
            endcase
        end
        if (access && !pready) begin
            next_prdata = 32'h0000_0000;
            if (!pwrite) begin
                case (idx)
                    (AW-2)'(`DTPG_IDX_WB_GAIN): next_prdata[0] = wideband_double_gain;
                    (AW-2)'(`DTPG_IDX_UW1_LOW):  next_prdata[7:0] = user_word_one[7:0];
                    (AW-2)'(`DTPG_IDX_UW1_HIGH): next_prdata[7:0] = user_word_one[15:8];
                    (AW-2)'(`DTPG_IDX_UW2_LOW):  next_prdata[7:0] = user_word_two[7:0];
                    (AW-2)'(`DTPG_IDX_UW2_HIGH): next_prdata[7:0] = user_word_two[15:8];
                    // the path one Q field is write-only and reads back as zero
                    (AW-2)'(`DTPG_IDX_SEL_ONE): next_prdata[3:0] = path_one_pattern_select[3:0];
                    (AW-2)'(`DTPG_IDX_SEL_TWO): next_prdata[7:0] = path_two_pattern_select;
                    (AW-2)'(`DTPG_IDX_COMMON):  next_prdata[0]   = per_stream_select;
                    default:                    next_prdata      = 32'h0000_0000;
                endcase
                if (!hit) begin
                    next_prdata = 32'h0000_0000;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wideband_double_gain    <= 1'b0;
            user_word_one           <= `DTPG_RST_WORD;
            user_word_two           <= `DTPG_RST_WORD;
            path_one_pattern_select <= `DTPG_RST_BYTE;
            path_two_pattern_select <= `DTPG_RST_BYTE;
            per_stream_select       <= 1'b0;
            prdata                  <= 32'h0000_0000;
            pready                  <= 1'b0;
            pslverr                 <= 1'b0;
        end else begin
            wideband_double_gain    <= next_wideband_double_gain;
            user_word_one           <= next_user_word_one;
            user_word_two           <= next_user_word_two;
            path_one_pattern_select <= next_path_one_pattern_select;
            path_two_pattern_select <= next_path_two_pattern_select;
            per_stream_select       <= next_per_stream_select;
            prdata                  <= next_prdata;
            pready                  <= next_pready;
            pslverr                 <= next_pslverr;
        end
    end

    // stream order: 0 = path one I, 1 = path one Q, 2 = path two I, 3 = path two Q
    assign conv[0]    = conv_i1;
    assign conv[1]    = conv_q1;
    assign conv[2]    = conv_i2;
    assign conv[3]    = conv_q2;
    assign own_sel[0] = path_one_pattern_select[`DTPG_SEL_I_LSB +: 4];
    assign own_sel[1] = path_one_pattern_select[`DTPG_SEL_Q_LSB +: 4];
    assign own_sel[2] = path_two_pattern_select[`DTPG_SEL_I_LSB +: 4];
    assign own_sel[3] = path_two_pattern_select[`DTPG_SEL_Q_LSB +: 4];

    // free-running phase and ramp; shared so all streams stay aligned
    always_comb begin
        next_phase = ~phase;
        next_ramp  = ramp + 16'h0001;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= 1'b0;
            ramp  <= `DTPG_RST_WORD;
        end else begin
            phase <= next_phase;
            ramp  <= next_ramp;
        end
    end

    // per-stream pattern selection
    for (genvar g = 0; g < 4; g++) begin : g_stream
        assign eff_sel[g] = per_stream_select ? own_sel[g] : own_sel[0];
        // gain is gated by the path mode so narrower decimations are never scaled
        assign live[g] = (wideband_double_gain && wideband_path) ?
                         sat_double(conv[g]) : conv[g];

        always_comb begin
            case (eff_sel[g])
                PAT_LIVE:   next_out[g] = live[g];
                PAT_ZEROS:  next_out[g] = 16'h0000;
                PAT_ONES:   next_out[g] = 16'hFFFF;
                PAT_TOGGLE: next_out[g] = phase ? `DTPG_TOGGLE_B : `DTPG_TOGGLE_A;
                PAT_RAMP:   next_out[g] = ramp;
                PAT_SINGLE: next_out[g] = user_word_one;
                PAT_DOUBLE: next_out[g] = phase ? user_word_two : user_word_one;
                PAT_DESKEW: next_out[g] = `DTPG_DESKEW_WORD;
                PAT_SYNC:   next_out[g] = `DTPG_SYNC_WORD;
                default:    next_out[g] = live[g];
            endcase
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                out_q[g] <= `DTPG_RST_WORD;
            end else begin
                out_q[g] <= next_out[g];
            end
        end
    end

    assign out_i1 = out_q[0];
    assign out_q1 = out_q[1];
    assign out_i2 = out_q[2];
    assign out_q2 = out_q[3];

    // checks on stream behaviour and on a user word one low write
    property p_gain;
        @(posedge pclk) disable iff (!presetn)
        (eff_sel[0] == 4'h0 && wideband_double_gain && wideband_path
            && conv_i1[15] == conv_i1[14])
            |=> out_i1 == 16'($past(conv_i1) << 1);
    endproperty
    a_gain: assert property (p_gain) else $error("wideband gain not applied");

    property p_narrow;
        @(posedge pclk) disable iff (!presetn)
        (eff_sel[0] == 4'h0 && !wideband_path) |=> out_i1 == $past(conv_i1);
    endproperty
    a_narrow: assert property (p_narrow) else $error("narrow path was scaled");

    property p_word_low;
        @(posedge pclk) disable iff (!presetn)
        (wr_fire && paddr == AW'({`DTPG_IDX_UW1_LOW, 2'b00}))
            |=> user_word_one[7:0] == $past(pwdata[7:0]);
    endproperty
    a_word_low: assert property (p_word_low) else $error("user word one low lost");

    property p_zeros;
        @(posedge pclk) disable iff (!presetn)
        eff_sel[3] == 4'h1 |=> out_q2 == 16'h0000;
    endproperty
    a_zeros: assert property (p_zeros) else $error("zeros pattern wrong");

    property p_toggle;
        @(posedge pclk) disable iff (!presetn)
        (eff_sel[0] == 4'h3)[*2] |-> ##1 (out_i1 ^ $past(out_i1)) == 16'h3FFF;
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle did not alternate");

    property p_ramp;
        @(posedge pclk) disable iff (!presetn)
        (eff_sel[0] == 4'h4 ##1 eff_sel[0] == 4'h4) |=> out_i1 == $past(out_i1) + 16'h0001;
    endproperty
    a_ramp: assert property (p_ramp) else $error("ramp step wrong");

    property p_double;
        @(posedge pclk) disable iff (!presetn)
        (eff_sel[0] == 4'h7 && !phase) |=> out_i1 == $past(user_word_one) ##1
            (eff_sel[0] != 4'h7 || out_i1 == $past(user_word_two));
    endproperty
    a_double: assert property (p_double) else $error("double pattern order wrong");

    property p_fixed;
        @(posedge pclk) disable iff (!presetn)
        (eff_sel[0] == 4'h8 |=> out_i1 == 16'hAAAA) and (eff_sel[0] == 4'h9 |=> out_i1 == 16'hFFFF);
    endproperty
    a_fixed: assert property (p_fixed) else $error("fixed word wrong");

    property p_common;
        @(posedge pclk) disable iff (!presetn)
        (!per_stream_select && path_one_pattern_select[3:0] == 4'h1)
            |=> (out_q1 | out_i2 | out_q2) == 16'h0000;
    endproperty
    a_common: assert property (p_common) else $error("common select ignored");

    property p_undef;
        @(posedge pclk) disable iff (!presetn)
        (eff_sel[0] == 4'h5 || eff_sel[0] >= 4'hA) |=> out_i1 == $past(live[0]);
    endproperty
    a_undef: assert property (p_undef) else $error("undefined code not live");

    c_ramp_wrap: cover property (@(posedge pclk) disable iff (!presetn)
        eff_sel[0] == 4'h4 && ramp == 16'hFFFF ##1 ramp == 16'h0000);
    c_double:    cover property (@(posedge pclk) disable iff (!presetn) (eff_sel[1] == 4'h7)[*3]);
    c_gain:      cover property (@(posedge pclk) disable iff (!presetn)
        wideband_double_gain && wideband_path && eff_sel[0] == 4'h0);
    c_unmapped:  cover property (@(posedge pclk) disable iff (!presetn) pready && pslverr);

endmodule

// ### tb/ddc_output_test_pattern_gen_tb.sv
// Purpose: self-checking bench for the output pattern generator
// Assumes: one wait state per APB transfer, outputs lag by one cycle
// Notes:   expectations queued by the drivers, checked by watchers
`timescale 1ns/100ps
`include "dtpg_defines.svh"
module ddc_output_test_pattern_gen_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        wideband_path, probe, got_valid, gain_on;
    logic [15:0] conv [4];
    logic [15:0] oi1, oq1, oi2, oq2;
    logic [63:0] got_word, got_xor, got_step, got;
    logic [15:0] uw1 = 16'h1234;
    logic [15:0] uw2 = 16'h5678;
    logic [9:0]  aq [$];
    logic [65:0] sq [$];
    logic [9:0]  ae;
    logic [65:0] se;
    logic [3:0]  codes [13] = '{4'h0, 4'h1, 4'h2, 4'h6, 4'h8, 4'h9, 4'h5, 4'hA, 4'hB,
        4'hC, 4'hD, 4'hE, 4'hF};
    logic [7:0]  ri [8] = '{`DTPG_IDX_WB_GAIN, `DTPG_IDX_UW1_LOW, `DTPG_IDX_UW1_HIGH,
        `DTPG_IDX_UW2_LOW, `DTPG_IDX_UW2_HIGH, `DTPG_IDX_SEL_ONE, `DTPG_IDX_SEL_TWO,
        `DTPG_IDX_COMMON};
    int          fails, compares, seed;

    // 200 MHz clock
    always #2.5 pclk = ~pclk;

    dtpg_top dtpg_top_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .wideband_path(wideband_path),
        .conv_i1(conv[3]), .conv_q1(conv[2]), .conv_i2(conv[1]), .conv_q2(conv[0]),
        .out_i1(oi1), .out_q1(oq1), .out_i2(oi2), .out_q2(oq2));

    dtpg_sink dtpg_sink_inst (.pclk(pclk), .presetn(presetn), .lanes({oi1, oq1, oi2, oq2}),
        .probe(probe), .got_valid(got_valid), .got_word(got_word), .got_xor(got_xor),
        .got_step(got_step));

    task automatic give_verdict();
        $display("counts: compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // one APB transfer; the master holds everything until pready is seen or 50 cycles pass
    task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d,
                       input logic [7:0] rexp, input logic err);
        int n;
        aq.push_back({~w, err, rexp});
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            fails++;
            $display("FAIL %0t apb timeout", $time);
            give_verdict();
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb({2'b00, idx, 2'b00}, 1'b1, d, 8'h00, 1'b0);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] e);
        apb({2'b00, idx, 2'b00}, 1'b0, 8'h00, e, 1'b0);
    endtask

    task automatic setall(input logic [3:0] c);
        wr(`DTPG_IDX_SEL_ONE, {c, c});
        wr(`DTPG_IDX_SEL_TWO, {c, c});
    endtask

    // expected lane value for a selector code and live sample
    function automatic logic [15:0] lanev(input logic [3:0] c, input logic [15:0] x);
        case (c)
            4'h1: lanev = 16'h0000;
            4'h2: lanev = 16'hFFFF;
            4'h6: lanev = uw1;
            4'h8: lanev = 16'hAAAA;
            4'h9: lanev = 16'hFFFF;
            default: lanev = !gain_on ? x :
                (x[15] != x[14]) ? {x[15], {15{~x[15]}}} : {x[14:0], 1'b0};
        endcase
    endfunction

    // hold one live sample, then capture the settled lanes once
    task automatic check_word(input logic [15:0] c);
        logic [15:0] x;
        logic [63:0] e;
        @(posedge pclk);
        for (int k = 0; k < 4; k++) begin
            x = 16'($random(seed));
            conv[k] <= x;
            e[16*k +: 16] = lanev(c[4*k +: 4], x);
        end
        @(posedge pclk);
        probe <= 1'b1;
        sq.push_back({2'd0, e});
        @(posedge pclk);
        probe <= 1'b0;
    endtask

    // capture n consecutive samples; live data keeps changing meanwhile
    task automatic check_seq(input logic [1:0] kind, input logic [63:0] e, input int n);
        // skip one sample so the first compared pair comes from the new pattern only
        @(posedge pclk);
        for (int j = 0; j < n; j++) begin
            @(posedge pclk);
            probe <= 1'b1;
            for (int k = 0; k < 4; k++) conv[k] <= 16'($random(seed));
            sq.push_back({kind, e});
        end
        @(posedge pclk);
        probe <= 1'b0;
    endtask

    // watcher of completed APB transfers
    always @(posedge pclk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            ae = aq.pop_front();
            compares++;
            if (pslverr !== ae[8] || (ae[9] && prdata !== {24'h00_0000, ae[7:0]})) begin
                fails++;
                $display("FAIL %0t apb at %h got %h err %b", $time, paddr, prdata, pslverr);
            end
        end
    end

    // watcher of receiver reports
    always @(negedge pclk) begin
        if (got_valid === 1'b1) begin
            se = sq.pop_front();
            got = (se[65:64] == 2'd0) ? got_word : (se[65:64] == 2'd1) ? got_xor : got_step;
            compares++;
            if (got !== se[63:0]) begin
                fails++;
                $display("FAIL %0t stream got %h exp %h", $time, got, se[63:0]);
            end
        end
    end

    initial begin
        {pclk, presetn, psel, penable, pwrite, probe, wideband_path, gain_on} = 8'h00;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        seed = 32'ha5db;
        for (int k = 0; k < 4; k++) conv[k] = 16'h0000;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        foreach (ri[k]) rd(ri[k], 8'h00);
        apb(12'h000, 1'b0, 8'h00, 8'h00, 1'b1);
        apb(12'h0CD, 1'b0, 8'h00, 8'h00, 1'b1);
        apb(12'h0E8, 1'b1, 8'h55, 8'h00, 1'b1);
        $display("test reset_and_map done");
        wr(`DTPG_IDX_UW1_LOW, uw1[7:0]);
        wr(`DTPG_IDX_UW1_HIGH, uw1[15:8]);
        wr(`DTPG_IDX_UW2_LOW, uw2[7:0]);
        wr(`DTPG_IDX_UW2_HIGH, uw2[15:8]);
        rd(`DTPG_IDX_UW1_LOW, uw1[7:0]);
        rd(`DTPG_IDX_UW1_HIGH, uw1[15:8]);
        rd(`DTPG_IDX_UW2_LOW, uw2[7:0]);
        rd(`DTPG_IDX_UW2_HIGH, uw2[15:8]);
        wr(`DTPG_IDX_SEL_ONE, 8'hF1);
        rd(`DTPG_IDX_SEL_ONE, 8'h01);
        wr(`DTPG_IDX_SEL_TWO, 8'h99);
        rd(`DTPG_IDX_SEL_TWO, 8'h99);
        check_word({4{4'h1}});
        wr(`DTPG_IDX_COMMON, 8'h01);
        rd(`DTPG_IDX_COMMON, 8'h01);
        wr(`DTPG_IDX_SEL_ONE, 8'h91);
        wr(`DTPG_IDX_SEL_TWO, 8'h28);
        check_word(16'h1982);
        $display("test selectors done");
        foreach (codes[k]) begin
            setall(codes[k]);
            check_word({4{codes[k]}});
        end
        setall(4'h3);
        check_seq(2'd1, {4{16'h3FFF}}, 8);
        setall(4'h7);
        check_seq(2'd1, {4{uw1 ^ uw2}}, 8);
        setall(4'h4);
        check_seq(2'd2, {4{16'h0001}}, 65540);
        $display("test patterns done");
        wr(`DTPG_IDX_WB_GAIN, 8'h01);
        rd(`DTPG_IDX_WB_GAIN, 8'h01);
        setall(4'h0);
        wideband_path <= 1'b1;
        gain_on = 1'b1;
        repeat (6) check_word(16'h0000);
        setall(4'h6);
        check_word({4{4'h6}});
        setall(4'h0);
        wideband_path <= 1'b0;
        gain_on = 1'b0;
        repeat (3) check_word(16'h0000);
        $display("test gain done");
        repeat (4) @(posedge pclk);
        if (aq.size() != 0 || sq.size() != 0) begin
            fails++;
            $display("FAIL %0t results missing", $time);
        end
        give_verdict();
    end
endmodule

// ### tb/dtpg_sink.sv
// Purpose: receiving end of the four output streams
// Assumes: one sample per stream per pclk, lanes packed i1,q1,i2,q2
// Notes:   reports word, xor and step against the previous sample
`timescale 1ns/100ps
module dtpg_sink (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // streams from the generator
    input  wire logic [63:0] lanes,
    // capture request
    input  wire logic        probe,
    // reports
    output logic             got_valid,
    output logic      [63:0] got_word,
    output logic      [63:0] got_xor,
    output logic      [63:0] got_step
);
    logic [63:0] prev;
    logic [63:0] next_step;

    // per-lane step wraps modulo 2^16, so a ramp wrap still reads as one
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            next_step[16*k +: 16] = lanes[16*k +: 16] - prev[16*k +: 16];
        end
    end

    // the receiver sees every sample but reports only on request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev      <= 64'h0000_0000_0000_0000;
            got_valid <= 1'b0;
            got_word  <= 64'h0000_0000_0000_0000;
            got_xor   <= 64'h0000_0000_0000_0000;
            got_step  <= 64'h0000_0000_0000_0000;
        end else begin
            prev      <= lanes;
            got_valid <= probe;
            got_word  <= lanes;
            got_xor   <= lanes ^ prev;
            got_step  <= next_step;
        end
    end
endmodule
